// file: svm_gain_select.sv
// Gain set selection and loop tuning registers for a servo drive
`include "svm_regs.svh"

module svm_gain_select (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  // Avalon-MM slave
  input  wire svm_pkg::svm_bus_req_s avs_req,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // Digital input pins
  input  wire logic                 gain_switch0,
  input  wire logic                 gain_switch1,
  input  wire logic                 mode_control_input,
  // Control loop timing and status
  input  wire logic                 loop_tick,
  input  wire logic                 position_reached,
  input  wire svm_pkg::svm_tune_s   tune,
  // Loop outputs
  output svm_pkg::svm_loop_s        loop_gains,
  output logic [1:0]                current_gain_index,
  output logic [7:0]                op_mode,
  output logic                      limit_status,
  output logic                      limit_display
);

  svm_pkg::svm_state_s state_reg;
  svm_pkg::svm_state_s state_next;

  logic [2:0]  pin_raw;
  logic        bus_req;
  logic        wr_hit;
  logic [23:0] pkp_prod;
  logic [15:0] wr16;
  logic [1:0]  idx_sel;
  logic        auto_mode;

  assign pin_raw = {mode_control_input, gain_switch1, gain_switch0};
  assign bus_req = avs_req.read | avs_req.write;
  assign wr_hit  = avs_req.write & state_reg.ack;
  assign wr16    = avs_req.writedata[15:0];

  // Saturate so a large bandwidth never wraps into a small gain
  assign pkp_prod = 24'(wr16) * 24'(`SVM_PKP_PER_HZ);

  // Automatic switching only in pulse, position and velocity modes
  assign auto_mode = (state_reg.mode == `SVM_MODE_PULSE) ||
                     (state_reg.mode == `SVM_MODE_PROF_POS) ||
                     (state_reg.mode == `SVM_MODE_PROF_VEL);

  // Gain set choice from pins or position reached
  always_comb begin
    if (state_reg.gain_din) begin
      idx_sel = {state_reg.pin[1], state_reg.pin[0]};
    end else if (state_reg.auto_sw && auto_mode) begin
      idx_sel = position_reached ? 2'h1 : 2'h0;
    end else begin
      idx_sel = 2'h0;
    end
  end

  // Next state
  always_comb begin
    state_next = state_reg;

    // One wait cycle per access; answer lands as waitrequest drops
    state_next.ack = bus_req & ~state_reg.ack;

    // Pin synchronisers; level accepted once stages two and three agree
    for (int i = 0; i < 3; i++) begin
      state_next.sync[i] = {state_reg.sync[i][1:0], pin_raw[i]};
      if (state_reg.sync[i][1] == state_reg.sync[i][2]) begin
        state_next.pin[i] = state_reg.sync[i][2];
      end
    end

    // Read data captured in the cycle before the answer
    if (avs_req.read && !state_reg.ack) begin
      unique case (avs_req.address)
        `SVM_OFF_VKP0:     state_next.rdata = {16'h0000, state_reg.vkp[0]};
        `SVM_OFF_VKI0:     state_next.rdata = {16'h0000, state_reg.vki[0]};
        `SVM_OFF_PKP0:     state_next.rdata = {16'h0000, state_reg.pkp[0]};
        `SVM_OFF_VKP1:     state_next.rdata = {16'h0000, state_reg.vkp[1]};
        `SVM_OFF_VKI1:     state_next.rdata = {16'h0000, state_reg.vki[1]};
        `SVM_OFF_PKP1:     state_next.rdata = {16'h0000, state_reg.pkp[1]};
        `SVM_OFF_VKP2:     state_next.rdata = {16'h0000, state_reg.vkp[2]};
        `SVM_OFF_VKI2:     state_next.rdata = {16'h0000, state_reg.vki[2]};
        `SVM_OFF_PKP2:     state_next.rdata = {16'h0000, state_reg.pkp[2]};
        `SVM_OFF_VKP3:     state_next.rdata = {16'h0000, state_reg.vkp[3]};
        `SVM_OFF_VKI3:     state_next.rdata = {16'h0000, state_reg.vki[3]};
        `SVM_OFF_PKP3:     state_next.rdata = {16'h0000, state_reg.pkp[3]};
        `SVM_OFF_GAIN_IDX: state_next.rdata = {30'h0, state_reg.idx};
        `SVM_OFF_VFF:      state_next.rdata = {16'h0000, state_reg.vff};
        `SVM_OFF_AFF:      state_next.rdata = {16'h0000, state_reg.aff};
        `SVM_OFF_PBW:      state_next.rdata = {16'h0000, state_reg.pbw};
        `SVM_OFF_PFILT:    state_next.rdata = {16'h0000, state_reg.pfilt};
        `SVM_OFF_SFB:      state_next.rdata = {16'h0000, state_reg.sfb};
        `SVM_OFF_VBW:      state_next.rdata = {16'h0000, state_reg.vbw};
        `SVM_OFF_CTRL:     state_next.rdata = {28'h0, state_reg.lim_dis,
                                               state_reg.mode_din,
                                               state_reg.gain_din,
                                               state_reg.auto_sw};
        `SVM_OFF_MODE:     state_next.rdata = {16'h0000, state_reg.mode1,
                                               state_reg.mode0};
        `SVM_OFF_STATUS:   state_next.rdata = {16'h0000, state_reg.mode,
                                               5'h00, ~state_reg.lim_dis,
                                               state_reg.idx};
        default:           state_next.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes; unmapped addresses are dropped
    if (wr_hit) begin
      unique case (avs_req.address)
        `SVM_OFF_VKP0: state_next.vkp[0] = wr16;
        `SVM_OFF_VKI0: state_next.vki[0] = wr16;
        `SVM_OFF_PKP0: state_next.pkp[0] = wr16;
        `SVM_OFF_VKP1: state_next.vkp[1] = wr16;
        `SVM_OFF_VKI1: state_next.vki[1] = wr16;
        `SVM_OFF_PKP1: state_next.pkp[1] = wr16;
        `SVM_OFF_VKP2: state_next.vkp[2] = wr16;
        `SVM_OFF_VKI2: state_next.vki[2] = wr16;
        `SVM_OFF_PKP2: state_next.pkp[2] = wr16;
        `SVM_OFF_VKP3: state_next.vkp[3] = wr16;
        `SVM_OFF_VKI3: state_next.vki[3] = wr16;
        `SVM_OFF_PKP3: state_next.pkp[3] = wr16;
        `SVM_OFF_VFF: begin
          state_next.vff = (wr16 > `SVM_VFF_MAX) ? `SVM_VFF_MAX : wr16;
        end
        `SVM_OFF_AFF:   state_next.aff = wr16;
        `SVM_OFF_PBW:   state_next.pbw = wr16;
        `SVM_OFF_PFILT: state_next.pfilt = wr16;
        `SVM_OFF_SFB: begin
          state_next.sfb = (wr16 > `SVM_SFB_MAX) ? `SVM_SFB_MAX : wr16;
        end
        `SVM_OFF_VBW: state_next.vbw = wr16;
        `SVM_OFF_CTRL: begin
          state_next.auto_sw  = avs_req.writedata[`SVM_CTRL_AUTO];
          state_next.gain_din = avs_req.writedata[`SVM_CTRL_GAIN_DIN];
          state_next.mode_din = avs_req.writedata[`SVM_CTRL_MODE_DIN];
          state_next.lim_dis  = avs_req.writedata[`SVM_CTRL_LIM_DIS];
        end
        `SVM_OFF_MODE: begin
          state_next.mode0 = avs_req.writedata[7:0];
          state_next.mode1 = avs_req.writedata[15:8];
        end
        default: ;
      endcase
    end

    // Bandwidth drives only the position gain of set 0
    if (wr_hit && avs_req.address == `SVM_OFF_PBW) begin
      state_next.pkp[0] = (pkp_prod[23:16] != 8'h00) ? 16'hffff
                                                       : 16'(pkp_prod);
    end

    // Auto-tuning result lands last so it wins over a bus write
    if (tune.valid) begin
      state_next.vkp[0] = tune.vkp;
      state_next.vki[0] = tune.vki;
      state_next.pkp[0] = tune.pkp;
    end

    // Mode follows the filtered mode pin when it is assigned
    state_next.mode = (state_reg.mode_din && state_reg.pin[2]) ? state_reg.mode1
                                                                : state_reg.mode0;

    // Loop parameters change only on a control loop update
    if (loop_tick) begin
      state_next.idx       = idx_sel;
      state_next.loop.vkp  = state_reg.vkp[idx_sel];
      state_next.loop.vki  = state_reg.vki[idx_sel];
      state_next.loop.pkp  = state_reg.pkp[idx_sel];
      state_next.loop.vff  = state_reg.vff;
      state_next.loop.aff  = state_reg.aff;
      state_next.loop.fb_hz = 16'(state_reg.sfb * `SVM_SFB_HZ_STEP +
                                  `SVM_SFB_HZ_BASE);
    end
  end

  // State register with reset defaults
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg          <= '0;
      state_reg.vkp      <= {4{`SVM_RST_VKP}};
      state_reg.vki      <= {4{`SVM_RST_VKI}};
      state_reg.pkp      <= {4{`SVM_RST_PKP}};
      state_reg.vff      <= `SVM_RST_VFF;
      state_reg.aff      <= `SVM_RST_AFF;
      state_reg.pbw      <= `SVM_RST_PBW;
      state_reg.pfilt    <= `SVM_RST_PFILT;
      state_reg.sfb      <= `SVM_RST_SFB;
      state_reg.mode0    <= `SVM_RST_MODE0;
      state_reg.mode1    <= `SVM_RST_MODE1;
      state_reg.mode     <= `SVM_RST_MODE0;
      state_reg.loop.vkp <= `SVM_RST_VKP;
      state_reg.loop.vki <= `SVM_RST_VKI;
      state_reg.loop.pkp <= `SVM_RST_PKP;
      state_reg.loop.vff <= `SVM_RST_VFF;
      state_reg.loop.aff <= `SVM_RST_AFF;
      state_reg.loop.fb_hz <= `SVM_RST_FBHZ;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata       = state_reg.rdata;
  assign avs_waitrequest    = ~state_reg.ack;
  assign loop_gains         = state_reg.loop;
  assign current_gain_index = state_reg.idx;
  assign op_mode            = state_reg.mode;
  assign limit_status       = ~state_reg.lim_dis;
  assign limit_display      = ~state_reg.lim_dis;

  // Pin-selected gain set reaches the loop on the next tick
  property p_pin_select;
    @(posedge core_clk) disable iff (srst)
      (loop_tick && state_reg.gain_din)
      |=> (current_gain_index == $past({state_reg.pin[1], state_reg.pin[0]}));
  endproperty
  a_pin_select: assert property (p_pin_select)
    else $error("gain index does not follow select pins");

  property p_auto_switch;
    @(posedge core_clk) disable iff (srst)
      (loop_tick && !state_reg.gain_din && state_reg.auto_sw && auto_mode)
      |=> (current_gain_index == {1'b0, $past(position_reached)});
  endproperty
  a_auto_switch: assert property (p_auto_switch)
    else $error("automatic switching picked wrong set");

  property p_auto_ignored;
    @(posedge core_clk) disable iff (srst)
      (loop_tick && state_reg.gain_din && !state_reg.pin[1] && !state_reg.pin[0])
      |=> (current_gain_index == 2'h0);
  endproperty
  a_auto_ignored: assert property (p_auto_ignored)
    else $error("automatic switching overrode select pins");

  property p_index_hold;
    @(posedge core_clk) disable iff (srst)
      !loop_tick |=> $stable(current_gain_index) && $stable(loop_gains);
  endproperty
  a_index_hold: assert property (p_index_hold)
    else $error("gain set changed between loop updates");

  property p_index_read;
    @(posedge core_clk) disable iff (srst)
      (avs_req.read && !avs_waitrequest && avs_req.address == `SVM_OFF_GAIN_IDX)
      |-> (avs_readdata == {30'h0, $past(current_gain_index)});
  endproperty
  a_index_read: assert property (p_index_read)
    else $error("gain index read mismatch");

  property p_tune_set0;
    @(posedge core_clk) disable iff (srst)
      tune.valid |=> (state_reg.vkp[0] == $past(tune.vkp)) &&
                     $stable(state_reg.vkp[3:1]) && $stable(state_reg.pkp[3:1]);
  endproperty
  a_tune_set0: assert property (p_tune_set0)
    else $error("auto-tuning touched wrong gain set");

  property p_bw_gain;
    @(posedge core_clk) disable iff (srst)
      (wr_hit && avs_req.address == `SVM_OFF_PBW && !tune.valid && wr16 < 16'h0100)
      |=> (state_reg.pkp[0] == 16'($past(wr16) * 16'd103)) && $stable(state_reg.pkp[1]);
  endproperty
  a_bw_gain: assert property (p_bw_gain)
    else $error("position gain not bandwidth times 103");

  property p_ranges;
    @(posedge core_clk) disable iff (srst)
      (state_reg.vff <= 16'h0100) && (state_reg.sfb <= 16'h002d);
  endproperty
  a_ranges: assert property (p_ranges)
    else $error("feedforward or filter setting out of range");

  property p_fb_hz;
    @(posedge core_clk) disable iff (srst)
      loop_tick |=> (loop_gains.fb_hz == 16'($past(state_reg.sfb) * 16'd20 + 16'd100));
  endproperty
  a_fb_hz: assert property (p_fb_hz)
    else $error("feedback filter bandwidth wrong");

  property p_mode_idle;
    @(posedge core_clk) disable iff (srst)
      (!state_reg.mode_din || !state_reg.pin[2]) |=> (op_mode == $past(state_reg.mode0));
  endproperty
  a_mode_idle: assert property (p_mode_idle)
    else $error("idle mode input did not select default mode");

  property p_limit;
    @(posedge core_clk) disable iff (srst)
      limit_status == !state_reg.lim_dis && limit_display == limit_status;
  endproperty
  a_limit: assert property (p_limit)
    else $error("limit status display mismatch");

  property p_bus_answer;
    @(posedge core_clk) disable iff (srst)
      (bus_req && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus request not answered in one cycle");

  // Active mode pin selects the second mode
  property p_mode_active;
    @(posedge core_clk) disable iff (srst)
      (state_reg.mode_din && state_reg.pin[2]) |=> (op_mode == $past(state_reg.mode1));
  endproperty
  a_mode_active: assert property (p_mode_active)
    else $error("active mode input did not select second mode");

  // Without pin selection or automatic switching set 0 stays in use
  property p_auto_off;
    @(posedge core_clk) disable iff (srst)
      (loop_tick && !state_reg.gain_din && !(state_reg.auto_sw && auto_mode))
      |=> (current_gain_index == 2'h0);
  endproperty
  a_auto_off: assert property (p_auto_off)
    else $error("gain set other than 0 without switching");

  property p_vff_clamp;
    @(posedge core_clk) disable iff (srst)
      (wr_hit && avs_req.address == `SVM_OFF_VFF && wr16 > 16'h0100)
      |=> (state_reg.vff == 16'h0100);
  endproperty
  a_vff_clamp: assert property (p_vff_clamp)
    else $error("velocity feedforward not clamped");

  property p_sfb_clamp;
    @(posedge core_clk) disable iff (srst)
      (wr_hit && avs_req.address == `SVM_OFF_SFB && wr16 > 16'h002d)
      |=> (state_reg.sfb == 16'h002d);
  endproperty
  a_sfb_clamp: assert property (p_sfb_clamp)
    else $error("feedback filter setting not clamped");

  // Bandwidth write leaves sets 1 to 3 alone
  property p_bw_other_sets;
    @(posedge core_clk) disable iff (srst)
      (wr_hit && avs_req.address == `SVM_OFF_PBW)
      |=> $stable(state_reg.pkp[3:1]) && $stable(state_reg.vkp[3:1]) &&
          $stable(state_reg.vki[3:1]);
  endproperty
  a_bw_other_sets: assert property (p_bw_other_sets)
    else $error("bandwidth write touched gain sets 1 to 3");

  // Feedforward settings reach the loop on a tick
  property p_ff_copy;
    @(posedge core_clk) disable iff (srst)
      loop_tick |=> (loop_gains.aff == $past(state_reg.aff)) &&
                    (loop_gains.vff == $past(state_reg.vff));
  endproperty
  a_ff_copy: assert property (p_ff_copy)
    else $error("feedforward not applied at loop update");

  property p_tune_rest;
    @(posedge core_clk) disable iff (srst)
      tune.valid |=> (state_reg.vki[0] == $past(tune.vki)) &&
                     (state_reg.pkp[0] == $past(tune.pkp));
  endproperty
  a_tune_rest: assert property (p_tune_rest)
    else $error("auto-tuning result not stored in set 0");

endmodule

// file: svm_gain_select_tb.sv
// Self-checking bench for the servo gain selector
`include "svm_regs.svh"

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end

module svm_gain_select_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  core_clk;
  logic                  srst;
  svm_pkg::svm_bus_req_s avs_req;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic                  gain_switch0;
  logic                  gain_switch1;
  logic                  mode_control_input;
  logic                  loop_tick;
  logic                  position_reached;
  svm_pkg::svm_tune_s    tune;
  svm_pkg::svm_loop_s    loop_gains;
  logic [1:0]            current_gain_index;
  logic [7:0]            op_mode;
  logic                  limit_status;
  logic                  limit_display;
  logic [1:0]            sel_cmd;
  logic                  mode_cmd;
  logic                  reached_cmd;
  logic                  tick_en;
  int                    mismatches;
  int                    tests_run;

  // Register reset table and per-set gain offsets
  logic [31:0] rst_off [8] = '{`SVM_OFF_VKP0, `SVM_OFF_VKI0, `SVM_OFF_PKP0, `SVM_OFF_VFF,
                               `SVM_OFF_AFF, `SVM_OFF_PBW, `SVM_OFF_PFILT, `SVM_OFF_SFB};
  logic [15:0] rst_val [8] = '{16'h0064, 16'h0002, 16'h03e8, 16'h0100,
                               16'h7fff, 16'h0000, 16'h0001, 16'h002d};
  logic [31:0] vkp_off [4] = '{`SVM_OFF_VKP0, `SVM_OFF_VKP1, `SVM_OFF_VKP2, `SVM_OFF_VKP3};
  logic [7:0]  auto_md [4] = '{8'hfc, 8'h01, 8'h03, 8'h06};

  svm_gain_select i_dut (
    .core_clk           (core_clk),
    .srst               (srst),
    .avs_req            (avs_req),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .gain_switch0       (gain_switch0),
    .gain_switch1       (gain_switch1),
    .mode_control_input (mode_control_input),
    .loop_tick          (loop_tick),
    .position_reached   (position_reached),
    .tune               (tune),
    .loop_gains         (loop_gains),
    .current_gain_index (current_gain_index),
    .op_mode            (op_mode),
    .limit_status       (limit_status),
    .limit_display      (limit_display)
  );

  svm_host_model i_host (
    .core_clk           (core_clk),
    .srst               (srst),
    .sel_cmd            (sel_cmd),
    .mode_cmd           (mode_cmd),
    .reached_cmd        (reached_cmd),
    .tick_en            (tick_en),
    .gain_switch0       (gain_switch0),
    .gain_switch1       (gain_switch1),
    .mode_control_input (mode_control_input),
    .position_reached   (position_reached),
    .loop_tick          (loop_tick)
  );

  // Avalon access held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge core_clk);
    avs_req <= {~wr, wr, a, wd};
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_req <= '0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    xfer(1'b1, a, d, rd);
  endtask

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] rd;
    xfer(1'b0, a, 32'h0, rd);
    `CHK(rd, e)
  endtask

  // Let pins pass the synchronisers, then ride one loop tick
  task automatic tick_wait();
    repeat (6) @(posedge core_clk);
    while (loop_tick !== 1'b1) begin
      @(posedge core_clk);
    end
    @(posedge core_clk);
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Free-running 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end

  // Main test sequence
  initial begin
    int i;
    mismatches = 0;
    tests_run = 0;
    srst = 1'b1;
    avs_req = '0;
    tune = '0;
    sel_cmd = 2'h0;
    mode_cmd = 1'b0;
    reached_cmd = 1'b0;
    tick_en = 1'b0;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    `CHK(loop_gains, {16'h0064, 16'h0002, 16'h03e8, 16'h0100, 16'h7fff, 16'h03e8})
    `CHK(op_mode, 8'hfc)
    `CHK({limit_status, limit_display}, 2'h3)
    for (i = 0; i < 8; i++) chk_rd(rst_off[i], {16'h0, rst_val[i]});
    wr(32'h30000000, 32'h1234);
    chk_rd(32'h30000000, 32'h0);
    end_test("reset");
    // Pin selection with auto switching also on and reached high
    wr(`SVM_OFF_CTRL, 32'h3);
    reached_cmd <= 1'b1;
    tick_en <= 1'b1;
    for (i = 0; i < 4; i++) wr(vkp_off[i], {16'h0, 16'(16'h0a00 + i)});
    for (i = 0; i < 4; i++) begin
      sel_cmd <= 2'(i);
      tick_wait();
      `CHK(current_gain_index, 2'(i))
      `CHK(loop_gains.vkp, 16'(16'h0a00 + i))
      chk_rd(`SVM_OFF_GAIN_IDX, 32'(i));
    end
    end_test("select");
    // No tick, no change of set
    tick_en <= 1'b0;
    sel_cmd <= 2'h1;
    repeat (12) @(posedge core_clk);
    `CHK(current_gain_index, 2'h3)
    tick_en <= 1'b1;
    tick_wait();
    `CHK(current_gain_index, 2'h1)
    end_test("tick");
    // Auto switching in each mode, plus one mode that ignores it
    wr(`SVM_OFF_CTRL, 32'h1);
    for (i = 0; i < 4; i++) begin
      wr(`SVM_OFF_MODE, {16'h0, 8'hfd, auto_md[i]});
      reached_cmd <= 1'b1;
      tick_wait();
      `CHK(op_mode, auto_md[i])
      `CHK(current_gain_index, (i < 3) ? 2'h1 : 2'h0)
      reached_cmd <= 1'b0;
      tick_wait();
      `CHK(current_gain_index, 2'h0)
    end
    end_test("auto");
    // Auto-tuning result lands in set 0 only
    @(posedge core_clk);
    tune <= {1'b1, 16'h0111, 16'h0222, 16'h0333};
    @(posedge core_clk);
    tune <= '0;
    chk_rd(`SVM_OFF_VKP0, 32'h0111);
    chk_rd(`SVM_OFF_VKI0, 32'h0222);
    chk_rd(`SVM_OFF_PKP0, 32'h0333);
    chk_rd(`SVM_OFF_VKP1, 32'h0a01);
    end_test("tune");
    // Bandwidths: position bandwidth times 103 into set 0 position gain only, saturating at ffff
    wr(`SVM_OFF_VBW, 32'h000a);
    wr(`SVM_OFF_PBW, 32'h0005);
    chk_rd(`SVM_OFF_PKP0, 32'h0203);
    chk_rd(`SVM_OFF_PKP1, 32'h03e8);
    chk_rd(`SVM_OFF_VKP2, 32'h0a02);
    wr(`SVM_OFF_VBW, 32'h0600);
    wr(`SVM_OFF_PBW, 32'h0300);
    chk_rd(`SVM_OFF_PKP0, 32'hffff);
    end_test("bandwidth");
    // Feedforward and feedback filter limits and formula
    wr(`SVM_OFF_VFF, 32'h0101);
    chk_rd(`SVM_OFF_VFF, 32'h0100);
    wr(`SVM_OFF_VFF, 32'h0000);
    chk_rd(`SVM_OFF_VFF, 32'h0000);
    wr(`SVM_OFF_SFB, 32'h002e);
    chk_rd(`SVM_OFF_SFB, 32'h002d);
    wr(`SVM_OFF_SFB, 32'h0014);
    wr(`SVM_OFF_AFF, 32'h000a);
    tick_wait();
    `CHK(loop_gains.fb_hz, 16'h01f4)
    `CHK(loop_gains.aff, 16'h000a)
    `CHK(loop_gains.vff, 16'h0000)
    wr(`SVM_OFF_SFB, 32'h0000);
    tick_wait();
    `CHK(loop_gains.fb_hz, 16'h0064)
    end_test("filter");
    // Mode pin idle gives pulse mode, active gives the second mode
    wr(`SVM_OFF_CTRL, 32'h4);
    wr(`SVM_OFF_MODE, 32'hfdfc);
    repeat (8) @(posedge core_clk);
    `CHK(op_mode, 8'hfc)
    mode_cmd <= 1'b1;
    repeat (8) @(posedge core_clk);
    `CHK(op_mode, 8'hfd)
    end_test("mode");
    // Limit status holds until limits are disabled
    `CHK({limit_status, limit_display}, 2'h3)
    wr(`SVM_OFF_CTRL, 32'h8);
    repeat (2) @(posedge core_clk);
    `CHK({limit_status, limit_display}, 2'h0)
    chk_rd(`SVM_OFF_CTRL, 32'h0000_0008);
    chk_rd(`SVM_OFF_STATUS, 32'h0000_fc00);
    end_test("limit");
    report_and_stop();
  end
endmodule

// file: svm_host_model.sv
// Host motion controller model: digital input pins and loop update ticks
module svm_host_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Commands from the bench
  input  wire logic [1:0] sel_cmd,
  input  wire logic       mode_cmd,
  input  wire logic       reached_cmd,
  input  wire logic       tick_en,
  // Pins toward the selector
  output logic            gain_switch0,
  output logic            gain_switch1,
  output logic            mode_control_input,
  output logic            position_reached,
  output logic            loop_tick
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] tick_cnt;

  // Pins change just after an edge, like a real controller output stage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gain_switch0       <= 1'b0;
      gain_switch1       <= 1'b0;
      mode_control_input <= 1'b0;
      position_reached   <= 1'b0;
      loop_tick          <= 1'b0;
      tick_cnt           <= 2'h0;
    end else begin
      gain_switch1       <= sel_cmd[1]; // Upper select bit
      gain_switch0       <= sel_cmd[0];
      mode_control_input <= mode_cmd;
      position_reached   <= reached_cmd;
      tick_cnt           <= tick_cnt + 2'h1;
      // Tick every fourth cycle; stopping it freezes the active set
      loop_tick          <= tick_en && (tick_cnt == 2'h3);
    end
  end
endmodule

// file: svm_pkg.sv
// Types shared by the servo gain selector
package svm_pkg;

  typedef logic [15:0] svm_word_t;

  // Avalon-MM slave request
  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [31:0] writedata;
  } svm_bus_req_s;

  // Auto-tuning result for one gain set
  typedef struct packed {
    logic      valid;
    svm_word_t vkp;
    svm_word_t vki;
    svm_word_t pkp;
  } svm_tune_s;

  // Gains applied to the control loops
  typedef struct packed {
    svm_word_t vkp;
    svm_word_t vki;
    svm_word_t pkp;
    svm_word_t vff;
    svm_word_t aff;
    svm_word_t fb_hz;
  } svm_loop_s;

  // Whole state of the selector
  typedef struct packed {
    logic                 ack;
    logic [31:0]          rdata;
    logic [2:0][2:0]      sync;
    logic [2:0]           pin;
    logic [3:0][15:0]     vkp;
    logic [3:0][15:0]     vki;
    logic [3:0][15:0]     pkp;
    svm_word_t            vff;
    svm_word_t            aff;
    svm_word_t            pbw;
    svm_word_t            vbw;
    svm_word_t            pfilt;
    svm_word_t            sfb;
    logic                 auto_sw;
    logic                 gain_din;
    logic                 mode_din;
    logic                 lim_dis;
    logic [7:0]           mode0;
    logic [7:0]           mode1;
    logic [7:0]           mode;
    logic [1:0]           idx;
    svm_loop_s            loop;
  } svm_state_s;

endpackage

// file: svm_regs.svh
// Register offsets, reset values and limits for the servo gain selector
`ifndef SVM_REGS_SVH
`define SVM_REGS_SVH

// Gain set registers
`define SVM_OFF_VKP0      32'h60f90110
`define SVM_OFF_VKI0      32'h60f90210
`define SVM_OFF_PKP0      32'h60fb0110
`define SVM_OFF_VKP1      32'h23400410
`define SVM_OFF_VKI1      32'h23400510
`define SVM_OFF_PKP1      32'h23400610
`define SVM_OFF_VKP2      32'h23400710
`define SVM_OFF_VKI2      32'h23400810
`define SVM_OFF_PKP2      32'h23400910
`define SVM_OFF_VKP3      32'h23400a10
`define SVM_OFF_VKI3      32'h23400b10
`define SVM_OFF_PKP3      32'h23400c10
`define SVM_OFF_GAIN_IDX  32'h60f92808

// Loop tuning registers
`define SVM_OFF_VFF       32'h20000000
`define SVM_OFF_AFF       32'h20000004
`define SVM_OFF_PBW       32'h20000008
`define SVM_OFF_PFILT     32'h2000000c
`define SVM_OFF_SFB       32'h20000010
`define SVM_OFF_VBW       32'h20000014
`define SVM_OFF_CTRL      32'h20000018
`define SVM_OFF_MODE      32'h2000001c
`define SVM_OFF_STATUS    32'h20000020

// Control register bit positions
`define SVM_CTRL_AUTO     0
`define SVM_CTRL_GAIN_DIN 1
`define SVM_CTRL_MODE_DIN 2
`define SVM_CTRL_LIM_DIS  3

// Reset values
`define SVM_RST_VKP       16'h0064
`define SVM_RST_VKI       16'h0002
`define SVM_RST_PKP       16'h03e8
`define SVM_RST_VFF       16'h0100
`define SVM_RST_AFF       16'h7fff
`define SVM_RST_PBW       16'h0000
`define SVM_RST_PFILT     16'h0001
`define SVM_RST_SFB       16'h002d
`define SVM_RST_FBHZ      16'h03e8
`define SVM_RST_MODE0     8'hfc
`define SVM_RST_MODE1     8'hfd

// Limits and scale factors
`define SVM_VFF_MAX       16'h0100
`define SVM_SFB_MAX       16'h002d
`define SVM_PKP_PER_HZ    16'h0067
`define SVM_SFB_HZ_STEP   16'h0014
`define SVM_SFB_HZ_BASE   16'h0064
`define SVM_MODE_PULSE    8'hfc
`define SVM_MODE_PROF_POS 8'h01
`define SVM_MODE_PROF_VEL 8'h03

`endif
